// ===== core/arb_map.svh
// Register offsets, field positions, reset values and counts of the arbiter
// Assumes byte addressing on a 32-bit APB, one register per aligned word
`ifndef ARB_MAP_SVH
`define ARB_MAP_SVH

// ------------------------------------------------------------
// Offsets
// ------------------------------------------------------------
`define ARB_ADDR_RSVD 8'h44
`define ARB_ADDR_CTRL 8'h48
`define ARB_ADDR_STAT 8'h80

// ------------------------------------------------------------
// Control word layout
// ------------------------------------------------------------
`define ARB_CTRL_RST 32'h0040801f
`define ARB_CTRL_WMASK 32'h07dffe1f
`define ARB_EN_LSB 0
`define ARB_EN_MSB 4
`define ARB_EXT_BIT 9
`define ARB_TMO_BIT 10
`define ARB_REFR_BIT 11
`define ARB_FAIR_LSB 12
`define ARB_FAIR_MSB 19
`define ARB_TOG_BIT 20
`define ARB_PRIO_LSB 22
`define ARB_PRIO_MSB 26

// ------------------------------------------------------------
// Status word layout
// ------------------------------------------------------------
`define ARB_ST_OWN_LSB 0
`define ARB_ST_OWN_MSB 2
`define ARB_ST_GNT_BIT 3
`define ARB_ST_BRK_LSB 4
`define ARB_ST_BRK_MSB 8
`define ARB_ST_DEAD_LSB 9
`define ARB_ST_DEAD_MSB 13
`define ARB_ST_FSM_LSB 14
`define ARB_ST_FSM_MSB 15

// ------------------------------------------------------------
// Counts and widths
// ------------------------------------------------------------
`define ARB_NREQ 5
`define ARB_IDX_W 3
`define ARB_TMO_CYC 16
`define ARB_TMO_W 5

`endif

// ===== core/arb_pkg.sv
// Types shared by the arbiter modules
// Assumes the constants of arb_map.svh for field positions
package arb_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GRANT = 2'b01,
    ST_BUSY = 2'b10,
    ST_DROP = 2'b11
  } arb_state_t;

endpackage : arb_pkg

// ===== core/arb_cfg_if.sv
// Configuration and status carried between register file and arbiter core
// Assumes one clock domain on both sides
`timescale 1ns/1ns
`default_nettype none

interface arb_cfg_if;
  logic [4:0] enable;
  logic [4:0] prio;
  logic ext_sel;
  logic tmo_en;
  logic refresh_en;
  logic tog_en;
  logic [7:0] fair_init;
  logic [31:0] status;

  modport regs (
    output enable, prio, ext_sel, tmo_en, refresh_en, tog_en, fair_init,
    input status
  );
  modport core (
    input enable, prio, ext_sel, tmo_en, refresh_en, tog_en, fair_init,
    output status
  );
endinterface : arb_cfg_if

`default_nettype wire

// ===== core/arb_apb_regs.sv
// APB slave holding the arbiter control word and showing its status
// Assumes an APB master; every access takes exactly one access cycle
`timescale 1ns/1ns
`default_nettype none
`include "arb_map.svh"

module arb_apb_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  arb_cfg_if.regs cfg
);

  if (ADDR_W < 8) begin : g_bad_addr
    $error("arb_apb_regs: ADDR_W must be at least 8");
  end

  logic [31:0] ctrl_r;
  logic setup;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_rsvd;

  assign setup = psel & ~penable;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  always_comb begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    hit_rsvd = 1'b0;
    if (paddr == ADDR_W'(`ARB_ADDR_CTRL)) begin
      hit_ctrl = 1'b1;
    end else if (paddr == ADDR_W'(`ARB_ADDR_STAT)) begin
      hit_stat = 1'b1;
    end else if (paddr == ADDR_W'(`ARB_ADDR_RSVD)) begin
      hit_rsvd = 1'b1;
    end
  end

  // One wait-free access: ready rises for the cycle after setup
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= ~(hit_ctrl | hit_stat | hit_rsvd);
      if (hit_ctrl && !pwrite) begin
        prdata <= ctrl_r;
      end else if (hit_stat && !pwrite) begin
        prdata <= cfg.status;
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // Reserved bits are not stored, so they always read back as zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `ARB_CTRL_RST;
    end else if (psel && penable && pready && pwrite && hit_ctrl) begin
      ctrl_r <= pwdata & `ARB_CTRL_WMASK;
    end
  end

  assign cfg.enable = ctrl_r[`ARB_EN_MSB:`ARB_EN_LSB];
  assign cfg.prio = ctrl_r[`ARB_PRIO_MSB:`ARB_PRIO_LSB];
  assign cfg.ext_sel = ctrl_r[`ARB_EXT_BIT];
  assign cfg.tmo_en = ctrl_r[`ARB_TMO_BIT];
  assign cfg.refresh_en = ctrl_r[`ARB_REFR_BIT];
  assign cfg.tog_en = ctrl_r[`ARB_TOG_BIT];
  assign cfg.fair_init = ctrl_r[`ARB_FAIR_MSB:`ARB_FAIR_LSB];

endmodule : arb_apb_regs

`default_nettype wire

// ===== core/arb_pick.sv
// Two-level round-robin picker over a request vector
// Assumes requests are already qualified by enable and broken state
`timescale 1ns/1ns
`default_nettype none

module arb_pick #(
  parameter int N = 5,
  parameter int IW = 3
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] high,
  input wire logic [IW-1:0] last,
  output logic [IW-1:0] win,
  output logic win_ok
);

  if (N < 2 || N > (1 << IW)) begin : g_bad_n
    $error("arb_pick: N must lie between 2 and 2**IW");
  end

  logic [IW-1:0] win_h;
  logic [IW-1:0] win_l;
  logic ok_h;
  logic ok_l;
  int idx;

  // Walk from the farthest to the nearest after the last owner
  always_comb begin
    win_h = '0;
    win_l = '0;
    ok_h = 1'b0;
    ok_l = 1'b0;
    idx = 0;
    for (int k = N; k >= 1; k--) begin
      idx = int'(last) + k;
      if (idx >= N) begin
        idx = idx - N;
      end
      if (req[idx] && high[idx]) begin
        win_h = IW'(idx);
        ok_h = 1'b1;
      end
      if (req[idx] && !high[idx]) begin
        win_l = IW'(idx);
        ok_l = 1'b1;
      end
    end
    win_ok = ok_h | ok_l;
    win = ok_h ? win_h : win_l;
  end

endmodule : arb_pick

`default_nettype wire

// ===== core/pci_arbiter.sv
// Secondary-bus PCI arbiter with its APB control and status registers
// Assumes PCI pins arrive asynchronously; internal requester is on clock
`timescale 1ns/1ns
`default_nettype none
`include "arb_map.svh"

module pci_arbiter #(
  parameter int ADDR_W = 8,
  parameter int TMO_CYC = `ARB_TMO_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_req,
  output logic int_gnt,
  input wire logic [3:0] req_l,
  input wire logic frame_l,
  output logic [3:0] gnt_l,
  output logic ext_arb_sel
);

  localparam int NREQ = `ARB_NREQ;
  localparam int IW = `ARB_IDX_W;
  localparam int TW = `ARB_TMO_W;

  if (TMO_CYC < 2 || TMO_CYC >= (1 << TW)) begin : g_bad_tmo
    $error("pci_arbiter: TMO_CYC must lie between 2 and 31");
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  arb_cfg_if cfg ();

  arb_apb_regs #(
    .ADDR_W(ADDR_W)
  ) u_regs (
    .clock(clock),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg.regs)
  );

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Bit 4 is FRAME_L, bits 3:0 are REQ_L; all idle high
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [4:0] pin_s3_r;
  logic [4:0] pin_f_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 5'h1f;
      pin_s2_r <= 5'h1f;
      pin_s3_r <= 5'h1f;
    end else begin
      pin_s1_r <= {frame_l, req_l};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // A level counts only once two stages agree, which masks a runt glitch
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_f_r <= 5'h1f;
    end else begin
      pin_f_r <= (~(pin_s2_r ^ pin_s3_r) & pin_s3_r) |
                 ((pin_s2_r ^ pin_s3_r) & pin_f_r);
    end
  end

  logic frame_act;
  logic frame_prev_r;
  logic frame_fall;
  logic [4:0] req_vec;

  assign frame_act = ~pin_f_r[4];
  assign frame_fall = frame_act & ~frame_prev_r;
  assign req_vec = {~pin_f_r[3:0], int_req};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_prev_r <= 1'b0;
    end else begin
      frame_prev_r <= frame_act;
    end
  end

  // ------------------------------------------------------------
  // Qualification and picking
  // ------------------------------------------------------------
  arb_pkg::arb_state_t state_r;
  arb_pkg::arb_state_t state_nxt;
  logic [IW-1:0] owner_r;
  logic [IW-1:0] owner_nxt;
  logic [IW-1:0] win;
  logic win_ok;
  logic [4:0] broken_r;
  logic [4:0] dead_r;
  logic [4:0] served_r;
  logic [4:0] elig;
  logic [4:0] own_vec;
  logic own_req;
  logic others_req;

  assign elig = req_vec & cfg.enable & ~broken_r & ~dead_r;
  assign own_vec = 5'h01 << owner_r;
  assign own_req = |(req_vec & own_vec);
  assign others_req = |(req_vec & ~own_vec & cfg.enable & ~broken_r &
                        ~dead_r);

  arb_pick #(
    .N(NREQ),
    .IW(IW)
  ) u_pick (
    .req(elig),
    .high(cfg.prio),
    .last(owner_r),
    .win(win),
    .win_ok(win_ok)
  );

  // ------------------------------------------------------------
  // Timeout and fairness counters
  // ------------------------------------------------------------
  logic [TW-1:0] tmo_cnt_r;
  logic tmo_hit;
  logic [7:0] fair_cnt_r;
  logic fair_hit;
  logic new_grant;

  assign tmo_hit = cfg.tmo_en && (state_r == arb_pkg::ST_GRANT) &&
                   !frame_act && (tmo_cnt_r == TW'(TMO_CYC - 1));
  assign fair_hit = (cfg.fair_init != 8'h00) &&
                    (state_r == arb_pkg::ST_BUSY) &&
                    others_req && (fair_cnt_r == 8'h00);
  assign new_grant = (state_r == arb_pkg::ST_IDLE) &&
                     (state_nxt == arb_pkg::ST_GRANT);

  // Counts only while granted, bus idle and no FRAME_L seen yet
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tmo_cnt_r <= '0;
    end else if (state_r != arb_pkg::ST_GRANT || !cfg.tmo_en) begin
      tmo_cnt_r <= '0;
    end else if (!frame_act) begin
      tmo_cnt_r <= tmo_cnt_r + TW'(1);
    end
  end

  // Decrement is armed by the move to busy on the first FRAME_L fall
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fair_cnt_r <= 8'h00;
    end else if (new_grant) begin
      fair_cnt_r <= cfg.fair_init;
    end else if (state_r == arb_pkg::ST_BUSY && others_req &&
                 fair_cnt_r != 8'h00) begin
      fair_cnt_r <= fair_cnt_r - 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Grant state machine
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    owner_nxt = owner_r;
    case (state_r)
      arb_pkg::ST_IDLE: begin
        if (!cfg.ext_sel && win_ok) begin
          state_nxt = arb_pkg::ST_GRANT;
          owner_nxt = win;
        end
      end
      arb_pkg::ST_GRANT: begin
        if (cfg.ext_sel || !own_req || tmo_hit) begin
          state_nxt = arb_pkg::ST_DROP;
        end else if (frame_fall) begin
          state_nxt = arb_pkg::ST_BUSY;
        end
      end
      arb_pkg::ST_BUSY: begin
        // With a zero fairness value only the owner's request or ext_sel ends it
        if (cfg.ext_sel || !own_req || fair_hit) begin
          state_nxt = arb_pkg::ST_DROP;
        end
      end
      arb_pkg::ST_DROP: begin
        state_nxt = arb_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = arb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= arb_pkg::ST_IDLE;
      owner_r <= '0;
    end else begin
      state_r <= state_nxt;
      owner_r <= owner_nxt;
    end
  end

  // ------------------------------------------------------------
  // Broken master bookkeeping
  // ------------------------------------------------------------
  logic [4:0] brk_set;
  logic brk_clr;
  logic [4:0] round_done;

  assign brk_set = tmo_hit ? own_vec : 5'h00;
  assign round_done = served_r | broken_r | dead_r | ~cfg.enable;
  assign brk_clr = cfg.refresh_en && (|broken_r) && (&round_done);

  // Set wins over the refresh clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      broken_r <= 5'h00;
    end else begin
      broken_r <= (brk_clr ? 5'h00 : broken_r) | brk_set;
    end
  end

  // Only a reset revives a master once it has gone dead
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dead_r <= 5'h00;
    end else if (!cfg.refresh_en) begin
      dead_r <= dead_r | (broken_r & ~req_vec);
    end
  end

  // Service round restarts whenever someone is newly marked broken
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      served_r <= 5'h00;
    end else if (|brk_set || brk_clr) begin
      served_r <= 5'h00;
    end else if (new_grant) begin
      served_r <= served_r | (5'h01 << owner_nxt);
    end
  end

  // ------------------------------------------------------------
  // Grant outputs
  // ------------------------------------------------------------
  logic tog_d_r;
  logic [4:0] gnt_nxt;

  // Pulse marks the clock after a granted FRAME_L fall
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tog_d_r <= 1'b0;
    end else begin
      tog_d_r <= cfg.tog_en && frame_fall &&
                 (state_r == arb_pkg::ST_GRANT ||
                  state_r == arb_pkg::ST_BUSY);
    end
  end

  // Without toggling the grant simply stays on through the frame
  always_comb begin
    gnt_nxt = 5'h00;
    if (state_nxt == arb_pkg::ST_GRANT || state_nxt == arb_pkg::ST_BUSY) begin
      gnt_nxt = 5'h01 << owner_nxt;
    end
    if (tog_d_r) begin
      gnt_nxt = 5'h00;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gnt_l <= 4'hf;
      int_gnt <= 1'b0;
    end else begin
      gnt_l <= ~gnt_nxt[4:1];
      int_gnt <= gnt_nxt[0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_arb_sel <= 1'b0;
    end else begin
      ext_arb_sel <= cfg.ext_sel;
    end
  end

  // ------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------
  always_comb begin
    cfg.status = 32'h0;
    cfg.status[`ARB_ST_OWN_MSB:`ARB_ST_OWN_LSB] = owner_r;
    cfg.status[`ARB_ST_GNT_BIT] = (state_r == arb_pkg::ST_GRANT) ||
                                  (state_r == arb_pkg::ST_BUSY);
    cfg.status[`ARB_ST_BRK_MSB:`ARB_ST_BRK_LSB] = broken_r;
    cfg.status[`ARB_ST_DEAD_MSB:`ARB_ST_DEAD_LSB] = dead_r;
    cfg.status[`ARB_ST_FSM_MSB:`ARB_ST_FSM_LSB] = state_r;
  end

endmodule : pci_arbiter

`default_nettype wire

// ===== verif/pci_master_model.sv
// Behavioural external masters on the request and frame pins
// Assumes the bench raises want to request once and lowers it to withdraw
`timescale 1ns/1ns
`default_nettype none

module pci_master_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] gnt_l,
  input wire logic [3:0] want,
  input wire logic [3:0] lazy,
  input wire logic [7:0] len,
  output logic [3:0] req_l,
  output logic frame_l
);
  // ----------------------------------------
  // Masters
  // ----------------------------------------
  logic [3:0] pend_r;
  logic [3:0] want_r;
  logic [3:0] own_r;
  logic [7:0] left_r;

  // Frame has a pull-up, so a released bus reads high
  assign frame_l = ~|own_r;
  assign req_l = ~pend_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 4'h0;
      want_r <= 4'h0;
      own_r <= 4'h0;
      left_r <= 8'h00;
    end else begin
      want_r <= want;
      pend_r <= (pend_r | (want & ~want_r)) & want;
      if (own_r != 4'h0) begin
        left_r <= left_r - 8'h01;
        if (left_r == 8'h01) begin
          own_r <= 4'h0;
          pend_r <= pend_r & ~own_r & want;
        end
      end else begin
        // Lazy masters never start, so they are the broken ones
        own_r <= pend_r & ~gnt_l & ~lazy;
        left_r <= len;
      end
    end
  end
endmodule : pci_master_model

`default_nettype wire

// ===== verif/arb_chk.sv
// Assertions on the arbiter's top-level ports
// Assumes control writes land at the APB access edge
`timescale 1ns/1ns
`default_nettype none

module arb_chk #(
  parameter int ADDR_W = 8,
  parameter int TMO_CYC = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic int_req,
  input wire logic int_gnt,
  input wire logic [3:0] req_l,
  input wire logic frame_l,
  input wire logic [3:0] gnt_l,
  input wire logic ext_arb_sel
);
  // ----------------------------------------
  // Shadow state
  // ----------------------------------------
  logic [31:0] ctrl_r;
  logic [5:0] idle_r;
  logic fell_r;
  logic [4:0] gv;

  assign gv = {~gnt_l, int_gnt};
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 32'h0040801f;
    end else if (psel && penable && pready && pwrite && paddr == 8'h48) begin
      ctrl_r <= pwdata & 32'h07dffe1f;
    end
  end

  // Saturates so a stuck grant cannot wrap back under the bound
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n || gv == 5'h00) begin
      idle_r <= 6'h00;
      fell_r <= 1'b0;
    end else begin
      fell_r <= fell_r | !frame_l;
      if (ctrl_r[10] && frame_l && !fell_r && idle_r != 6'h3f) begin
        idle_r <= idle_r + 6'h01;
      end
    end
  end

  a_pready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_pready_once: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside one access cycle");
  a_err_map: assert property
    (pready |-> pslverr == !(paddr inside {8'h44, 8'h48, 8'h80}))
    else $error("error flag wrong for address");
  a_rsvd_zero: assert property (pready && !pwrite && paddr == 8'h44
    |-> prdata == 32'h0) else $error("reserved word not zero");
  a_ctrl_read:
    assert property (pready && !pwrite && paddr == 8'h48 |-> prdata == ctrl_r)
    else $error("control word read wrong");
  a_one_owner:
    assert property ($onehot0(gv)) else $error("two grants at once");
  a_grant_gap: assert property ((gv & ~$past(gv)) != 5'h00
    |-> $past(gv) == 5'h00) else $error("grant moved without gap");
  a_int_enable:
    assert property ($rose(int_gnt) |-> $past(int_req) && ctrl_r[0])
    else $error("internal grant not enabled");
  a_ext_enable:
    assert property ((~gnt_l & $past(gnt_l) & ~ctrl_r[4:1]) == 4'h0)
    else $error("disabled master granted");
  a_ext_idle:
    assert property (ext_arb_sel && $past(ext_arb_sel) |-> gv == 5'h00)
    else $error("grant while external arbiter used");
  a_tmo_bound:
    assert property (idle_r <= TMO_CYC + 3) else $error("idle grant too long");
endmodule : arb_chk

bind pci_arbiter arb_chk #(.ADDR_W(ADDR_W), .TMO_CYC(TMO_CYC)) chk (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .int_req(int_req),
  .int_gnt(int_gnt), .req_l(req_l), .frame_l(frame_l), .gnt_l(gnt_l),
  .ext_arb_sel(ext_arb_sel)
);

`default_nettype wire

// ===== verif/pci_bus_arbiter_control_bench.sv
// Self-checking bench for the secondary-bus arbiter
// Assumes the master model drives the request and frame pins
`timescale 1ns/1ns
`default_nettype none

module pci_bus_arbiter_control_bench;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] r;
    logic e;
    logic x;
    logic g;
  } row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic int_req = 1'b0;
  logic [3:0] want = 4'h0;
  logic [3:0] lazy = 4'h0;
  logic [7:0] len = 8'h03;
  logic [31:0] prdata;
  logic pready, pslverr, int_gnt, frame_l, ext_arb_sel;
  logic [3:0] req_l, gnt_l;
  logic [4:0] gv;
  logic [4:0] g_q = 5'h0;
  logic [3:0] seq [$];
  logic [31:0] rd;
  logic er;
  int n;
  int n_mismatch = 0;
  int comparisons = 0;
  row_t rows [5] = '{
    '{8'h48, 32'hffffffff, 32'h07dffe1f, 1'b0, 1'b1, 1'b0},
    '{8'h48, 32'h00000000, 32'h00000000, 1'b0, 1'b0, 1'b0},
    '{8'h48, 32'h0040801f, 32'h0040801f, 1'b0, 1'b0, 1'b1},
    '{8'h44, 32'hffffffff, 32'h00000000, 1'b0, 1'b0, 1'b1},
    '{8'h40, 32'h12345678, 32'h00000000, 1'b1, 1'b0, 1'b1}};

  assign gv = {~gnt_l, int_gnt};
  always #4 clock = ~clock;

  pci_arbiter #(.ADDR_W(8), .TMO_CYC(16)) DUT (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .int_req(int_req), .int_gnt(int_gnt), .req_l(req_l),
    .frame_l(frame_l), .gnt_l(gnt_l), .ext_arb_sel(ext_arb_sel));
  pci_master_model peer (.clock(clock), .rst_n(rst_n), .gnt_l(gnt_l),
    .want(want), .lazy(lazy), .len(len), .req_l(req_l), .frame_l(frame_l));

  // Each new grant is logged; index 0 is the internal requester
  always @(posedge clock) begin
    for (int k = 0; k < 5; k++) begin
      if (gv[k] && !g_q[k]) seq.push_back(k[3:0]);
    end
    g_q = gv;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp, input string s);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s %h not %h", $time, s, seen, exp);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      t++;
    end while (pready !== 1'b1 && t < 20);
    // A slave that never answers counts against the run
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: no ready on bus", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task await(input int m);
    n = 0;
    while (seq.size() < m && n < 300) begin
      @(posedge clock);
      n++;
    end
    repeat (30) @(posedge clock);
  endtask : await

  task order(input logic [15:0] exp);
    logic [15:0] v;
    v = 16'h0;
    foreach (seq[k]) v = {v[11:0], seq[k]};
    seq.delete();
    check({16'h0, v}, {16'h0, exp}, "grant order");
  endtask : order

  task fair(input logic [31:0] cfg, input logic exp);
    apb(1'b1, 8'h48, cfg);
    len <= 8'h28;
    want <= 4'b0001;
    n = 0;
    while (frame_l !== 1'b0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    want <= 4'b0011;
    repeat (24) @(posedge clock);
    check({31'h0, gnt_l[0]}, {31'h0, exp}, "held grant");
    n = 0;
    while ((req_l !== 4'hf || gv !== 5'h0) && n < 300) begin
      @(posedge clock);
      n++;
    end
    want <= 4'h0;
  endtask : fair

  task fin(input string s);
    $display("test %s done", s);
  endtask : fin

  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // Far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    give_verdict;
  end

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    int_req <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].r, "read back");
      check({31'h0, er}, {31'h0, rows[i].e}, "error flag");
      repeat (4) @(posedge clock);
      check({ext_arb_sel, int_gnt}, {rows[i].x, rows[i].g}, "grant");
    end
    fin("registers");
    apb(1'b1, 8'h48, 32'h0240801f);
    want <= 4'b0111;
    repeat (8) @(posedge clock);
    seq.delete();
    int_req <= 1'b0;
    await(3);
    order(16'h0312);
    want <= 4'h0;
    fin("priority");
    apb(1'b1, 8'h48, 32'h0050801f);
    len <= 8'h0c;
    want <= 4'b0001;
    await(2);
    order(16'h0011);
    want <= 4'h0;
    fin("toggle");
    fair(32'h0040401f, 1'b1);
    fair(32'h0040001f, 1'b0);
    fin("fairness");
    apb(1'b1, 8'h48, 32'h0040841f);
    seq.delete();
    lazy <= 4'b1000;
    want <= 4'b1000;
    n = 0;
    while (gnt_l[3] !== 1'b0 && n < 40) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (gnt_l[3] === 1'b0 && n < 40) begin
      @(posedge clock);
      n++;
    end
    check({31'h0, n >= 15 && n <= 18}, 32'h1, "idle grant span");
    want <= 4'h0;
    repeat (4) @(posedge clock);
    want <= 4'b1000;
    repeat (40) @(posedge clock);
    order(16'h0004);
    apb(1'b0, 8'h80, 32'h0);
    check({27'h0, rd[13:9]}, 32'h10, "dead mask");
    fin("timeout");
    want <= 4'h0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    check({27'h0, gv}, 32'h0, "grants in reset");
    rst_n <= 1'b1;
    apb(1'b0, 8'h48, 32'h0);
    check(rd, 32'h0040801f, "control reset");
    fin("reset");
    apb(1'b1, 8'h48, 32'h00408c12);
    seq.delete();
    int_req <= 1'b1;
    len <= 8'h03;
    want <= 4'b1010;
    repeat (30) @(posedge clock);
    want <= 4'b1011;
    await(3);
    order(16'h0414);
    int_req <= 1'b0;
    want <= 4'h0;
    fin("refresh");
    give_verdict;
  end
endmodule : pci_bus_arbiter_control_bench

`default_nettype wire
